// file: roi_mode_csr.sv
`timescale 1ns/1ps
`default_nettype none
module roi_mode_csr (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               srst,
    // Quadlet access port
    input  wire logic               acc_req,
    input  wire logic               acc_write,
    input  wire logic [31:0]        acc_addr,
    input  wire logic [31:0]        acc_wdata,
    output logic                    acc_ack_r,
    output logic [31:0]             acc_rdata_r,
    // Camera control
    input  wire logic               initialize,
    input  wire logic               scalable_format_on,
    input  wire logic               active_mode,
    input  wire logic               capture_req,
    output logic                    capture_start_r,
    output logic                    capture_refused_r,
    output logic                    settings_apply_r,
    // Sensor temperature, quarter degrees
    input  wire logic signed [11:0] sensor_quarter_deg
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    localparam int ab = roi_csr_pkg::mode_span_bits;

    roi_mode_if mode_if [2] ();

    logic [1:0]  hit;
    logic [6:0]  off;
    logic        wr;
    logic        hit_thermal;
    logic [11:0] tenths;
    logic [31:0] origin_r   [2];
    logic [31:0] extent_r   [2];
    logic [7:0]  coding_r   [2];
    logic [15:0] payload_r  [2];
    logic [1:0]  err1_r;
    logic [1:0]  err2_r;
    logic [31:0] mode_rd    [2];
    logic [31:0] rdata_nxt;
    logic        abs_ctrl_r;

    assign hit[0]      = acc_req && (acc_addr[31:ab] == roi_csr_pkg::mode0_base[31:ab]);
    assign hit[1]      = acc_req && (acc_addr[31:ab] == roi_csr_pkg::mode1_base[31:ab]);
    assign off         = acc_addr[ab-1:0];
    assign wr          = acc_req && acc_write;
    assign hit_thermal = acc_req && (acc_addr == roi_csr_pkg::thermal_addr);

    thermal_scale u_thermal (
        .clock       (clock),
        .srst        (srst),
        .quarter_deg (sensor_quarter_deg),
        .tenths_r    (tenths)
    );

    // ------------------------------------------------------------
    // Per-mode register blocks
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_mode
        roi_mode_check u_check (
            .m (mode_if[i].check)
        );

        assign mode_if[i].origin  = origin_r[i];
        assign mode_if[i].extent  = extent_r[i];
        assign mode_if[i].coding  = coding_r[i];
        assign mode_if[i].payload = payload_r[i];

        // Writable settings; inquiry writes fall through
        always_ff @(posedge clock) begin
            if (srst) begin
                origin_r[i]  <= 32'h00000000;
                extent_r[i]  <= {roi_csr_pkg::max_width, roi_csr_pkg::max_height};
                payload_r[i] <= roi_csr_pkg::payload_default;
            end else if (wr && hit[i]) begin
                unique case (off)
                    roi_csr_pkg::off_origin:      origin_r[i]  <= acc_wdata;
                    roi_csr_pkg::off_extent:      extent_r[i]  <= acc_wdata;
                    roi_csr_pkg::off_payload_len: payload_r[i] <= acc_wdata[31:16];
                    default: ;
                endcase
            end
        end

        // Pixel format, default after reset or initialize
        always_ff @(posedge clock) begin
            if (srst || initialize) begin
                coding_r[i] <= roi_csr_pkg::format_default;
            end else if (wr && hit[i] && (off == roi_csr_pkg::off_format_select)) begin
                coding_r[i] <= acc_wdata[31:roi_csr_pkg::code_pos];
            end
        end

        // Error flags recomputed on every block access
        always_ff @(posedge clock) begin
            if (srst) begin
                err1_r[i] <= 1'b0;
                err2_r[i] <= 1'b0;
            end else if (hit[i]) begin
                err1_r[i] <= mode_if[i].err_first;
                err2_r[i] <= mode_if[i].err_second;
            end
        end

        // Read view of one block, computed fresh per access
        always_comb begin
            mode_rd[i] = 32'h00000000;
            unique case (off)
                roi_csr_pkg::off_max_extent:
                    mode_rd[i] = {roi_csr_pkg::max_width, roi_csr_pkg::max_height};
                roi_csr_pkg::off_step_unit:
                    mode_rd[i] = {roi_csr_pkg::unit_width, roi_csr_pkg::unit_height};
                roi_csr_pkg::off_origin:
                    mode_rd[i] = origin_r[i];
                roi_csr_pkg::off_extent:
                    mode_rd[i] = extent_r[i];
                roi_csr_pkg::off_format_select:
                    mode_rd[i] = {coding_r[i], 24'h000000};
                roi_csr_pkg::off_format_cap:
                    mode_rd[i] = roi_csr_pkg::format_cap_value;
                roi_csr_pkg::off_vendor_cap: begin
                    // First vendor word: bit n is coding 128+n
                    mode_rd[i][31 - 32'(roi_csr_pkg::packed_twelve_bit_mono_coding
                                      - roi_csr_pkg::vendor_coding_first)] = 1'b1;
                    mode_rd[i][31 - 32'(roi_csr_pkg::packed_twelve_bit_raw_coding
                                      - roi_csr_pkg::vendor_coding_first)] = 1'b1;
                end
                roi_csr_pkg::off_pixel_count:
                    mode_rd[i] = mode_if[i].pixels;
                roi_csr_pkg::off_bytes_upper:
                    mode_rd[i] = 32'h00000000;
                roi_csr_pkg::off_bytes_lower:
                    mode_rd[i] = mode_if[i].bytes;
                roi_csr_pkg::off_packet_params:
                    mode_rd[i] = {roi_csr_pkg::packet_size_granule,
                                  roi_csr_pkg::packet_max_bytes};
                roi_csr_pkg::off_payload_len:
                    mode_rd[i] = {payload_r[i], roi_csr_pkg::packet_max_bytes};
                roi_csr_pkg::off_value_setting: begin
                    mode_rd[i][roi_csr_pkg::presence_pos] = 1'b1;
                    mode_rd[i][roi_csr_pkg::err1_pos]     = mode_if[i].err_first;
                    mode_rd[i][roi_csr_pkg::err2_pos]     = mode_if[i].err_second;
                end
                default: mode_rd[i] = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Apply bit: pulse on write, never stored, reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            settings_apply_r <= 1'b0;
        end else begin
            settings_apply_r <= wr && (|hit) && (off == roi_csr_pkg::off_value_setting)
                             && acc_wdata[roi_csr_pkg::setting_pos];
        end
    end

    // ------------------------------------------------------------
    // Temperature register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            abs_ctrl_r <= 1'b0;
        end else if (wr && hit_thermal) begin
            abs_ctrl_r <= acc_wdata[roi_csr_pkg::abs_ctrl_pos];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (hit[0]) begin
            rdata_nxt = mode_rd[0];
        end else if (hit[1]) begin
            rdata_nxt = mode_rd[1];
        end else if (acc_addr == roi_csr_pkg::mode0_ptr_addr) begin
            rdata_nxt = roi_csr_pkg::mode0_ptr_value;
        end else if (acc_addr == roi_csr_pkg::mode1_ptr_addr) begin
            rdata_nxt = roi_csr_pkg::mode1_ptr_value;
        end else if (hit_thermal) begin
            rdata_nxt[roi_csr_pkg::presence_pos] = 1'b1;
            rdata_nxt[roi_csr_pkg::abs_ctrl_pos] = abs_ctrl_r;
            rdata_nxt[roi_csr_pkg::on_off_pos]   = 1'b1;
            rdata_nxt[11:0]                      = tenths;
        end
    end

    // Answer one cycle after each request
    always_ff @(posedge clock) begin
        if (srst) begin
            acc_ack_r   <= 1'b0;
            acc_rdata_r <= 32'h00000000;
        end else begin
            acc_ack_r   <= acc_req;
            acc_rdata_r <= (acc_req && !acc_write) ? rdata_nxt : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Capture gate
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            capture_start_r   <= 1'b0;
            capture_refused_r <= 1'b0;
        end else begin
            capture_start_r   <= capture_req && !(scalable_format_on
                              && (err1_r[active_mode] || err2_r[active_mode]));
            capture_refused_r <= capture_req && scalable_format_on
                              && (err1_r[active_mode] || err2_r[active_mode]);
        end
    end
endmodule : roi_mode_csr
`default_nettype wire

// file: roi_csr_pkg.sv
// Notes on behaviour
// - Mode base is F0000000h plus four times pointer
// - Any mode block access recomputes both error flags
// - Access refreshes mode registers; apply bit self-clears
// - No capture start while scalable format is on and the active mode flags error
// - Initialize or reset restores default pixel format
// - Packet inquiry always shows fixed size granule
// - Vendor codings 128-255; 132 mono12, 136 raw12
// - Temperature on/off bit always reads on
// - Temperature presence bit always reads one
// - Temperature value field is live and read-only
// - Temperature value is tenths of a degree Celsius
// - Temperature clamped to -55..150, quarter degree steps
package roi_csr_pkg;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] csr_space_base   = 32'hf0000000;
    localparam logic [31:0] mode0_ptr_addr   = 32'hf0f002e0;
    localparam logic [31:0] mode1_ptr_addr   = 32'hf0f002e4;
    localparam logic [31:0] mode0_ptr_value  = 32'h003c2000;
    localparam logic [31:0] mode1_ptr_value  = 32'h003c2400;
    localparam logic [31:0] mode0_base       = csr_space_base + (mode0_ptr_value << 2);
    localparam logic [31:0] mode1_base       = csr_space_base + (mode1_ptr_value << 2);
    localparam logic [31:0] thermal_addr     = 32'hf0f0082c;
    localparam int          mode_span_bits   = 7;

    // Offsets inside a mode block
    localparam logic [6:0] off_max_extent    = 7'h00;
    localparam logic [6:0] off_step_unit     = 7'h04;
    localparam logic [6:0] off_origin        = 7'h08;
    localparam logic [6:0] off_extent        = 7'h0c;
    localparam logic [6:0] off_format_select = 7'h10;
    localparam logic [6:0] off_format_cap    = 7'h14;
    localparam logic [6:0] off_vendor_cap    = 7'h24;
    localparam logic [6:0] off_pixel_count   = 7'h34;
    localparam logic [6:0] off_bytes_upper   = 7'h38;
    localparam logic [6:0] off_bytes_lower   = 7'h3c;
    localparam logic [6:0] off_packet_params = 7'h40;
    localparam logic [6:0] off_payload_len   = 7'h44;
    localparam logic [6:0] off_value_setting = 7'h7c;

    // ------------------------------------------------------------
    // Field positions (bit 0 of the map is the word's MSB)
    // ------------------------------------------------------------
    localparam int presence_pos  = 31;
    localparam int abs_ctrl_pos  = 30;
    localparam int on_off_pos    = 25;
    localparam int setting_pos   = 30;
    localparam int err1_pos      = 23;
    localparam int err2_pos      = 22;
    localparam int code_pos      = 24;

    // ------------------------------------------------------------
    // Pixel codings
    // ------------------------------------------------------------
    localparam logic [7:0] coding_mono8                  = 8'h00;
    localparam logic [7:0] coding_mono16                 = 8'h05;
    localparam logic [7:0] packed_twelve_bit_mono_coding = 8'h84;
    localparam logic [7:0] packed_twelve_bit_raw_coding  = 8'h88;
    localparam logic [7:0] vendor_coding_first           = 8'h80;

    // ------------------------------------------------------------
    // Inquiry values and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] max_width       = 16'h0800;
    localparam logic [15:0] max_height      = 16'h0600;
    localparam logic [15:0] unit_width      = 16'h0004;
    localparam logic [15:0] unit_height     = 16'h0002;
    localparam logic [15:0] packet_size_granule = 16'h0004;
    localparam logic [15:0] packet_max_bytes    = 16'h1000;
    localparam logic [31:0] format_cap_value    = 32'h84000000;
    localparam logic [7:0]  format_default      = coding_mono8;
    localparam logic [15:0] payload_default     = 16'h1000;

    // ------------------------------------------------------------
    // Temperature scaling, quarter degrees in, tenths out
    // ------------------------------------------------------------
    localparam logic signed [11:0] temp_min_tenths = -12'sd550;
    localparam logic signed [11:0] temp_max_tenths = 12'sd1500;
endpackage : roi_csr_pkg

// file: roi_mode_if.sv
`timescale 1ns/1ps
`default_nettype none
// Settings of one mode and the checks derived from them
interface roi_mode_if;
    logic [31:0] origin;
    logic [31:0] extent;
    logic [7:0]  coding;
    logic [15:0] payload;
    logic        err_first;
    logic        err_second;
    logic [31:0] pixels;
    logic [31:0] bytes;
    modport bank  (output origin, extent, coding, payload,
                   input  err_first, err_second, pixels, bytes);
    modport check (input  origin, extent, coding, payload,
                   output err_first, err_second, pixels, bytes);
endinterface : roi_mode_if
`default_nettype wire

// file: roi_mode_check.sv
`timescale 1ns/1ps
`default_nettype none
module roi_mode_check (
    roi_mode_if.check m
);
    logic [15:0] left;
    logic [15:0] top;
    logic [15:0] width;
    logic [15:0] height;
    logic [16:0] right_end;
    logic [16:0] bottom_end;

    assign left       = m.origin[31:16];
    assign top        = m.origin[15:0];
    assign width      = m.extent[31:16];
    assign height     = m.extent[15:0];
    assign right_end  = {1'b0, left} + {1'b0, width};
    assign bottom_end = {1'b0, top} + {1'b0, height};
    assign m.pixels   = width * height;

    // Frame size from coding; packed twelve bit is 1.5 bytes
    always_comb begin
        unique case (m.coding)
            roi_csr_pkg::coding_mono16:                 m.bytes = {m.pixels[30:0], 1'b0};
            roi_csr_pkg::packed_twelve_bit_mono_coding,
            roi_csr_pkg::packed_twelve_bit_raw_coding:  m.bytes = m.pixels + {1'b0, m.pixels[31:1]};
            default:                                    m.bytes = m.pixels;
        endcase
    end

    // Geometry error: empty, out of sensor, off unit grid or unsupported coding
    assign m.err_first  = (width == 16'h0000) || (height == 16'h0000)
                       || (right_end > {1'b0, roi_csr_pkg::max_width})
                       || (bottom_end > {1'b0, roi_csr_pkg::max_height})
                       || ((left % roi_csr_pkg::unit_width) != 16'h0000)
                       || ((width % roi_csr_pkg::unit_width) != 16'h0000)
                       || ((top % roi_csr_pkg::unit_height) != 16'h0000)
                       || ((height % roi_csr_pkg::unit_height) != 16'h0000)
                       || !((m.coding == roi_csr_pkg::coding_mono8)
                         || (m.coding == roi_csr_pkg::coding_mono16)
                         || (m.coding == roi_csr_pkg::packed_twelve_bit_mono_coding)
                         || (m.coding == roi_csr_pkg::packed_twelve_bit_raw_coding));
    // Packet error: empty, too long or off granule
    assign m.err_second = (m.payload == 16'h0000)
                       || (m.payload > roi_csr_pkg::packet_max_bytes)
                       || ((m.payload % roi_csr_pkg::packet_size_granule) != 16'h0000);
endmodule : roi_mode_check
`default_nettype wire

// file: thermal_scale.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_scale (
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic signed [11:0] quarter_deg,
    output logic        [11:0]      tenths_r
);
    logic signed [14:0] tenths_nxt;

    // Quarter degrees times 2.5 gives tenths
    always_comb begin
        tenths_nxt = (15'(quarter_deg) * 15'sd5) >>> 1;
    end

    // Clamp into displayed range
    always_ff @(posedge clock) begin
        if (srst) begin
            tenths_r <= 12'h000;
        end else if (tenths_nxt < 15'(roi_csr_pkg::temp_min_tenths)) begin
            tenths_r <= roi_csr_pkg::temp_min_tenths;
        end else if (tenths_nxt > 15'(roi_csr_pkg::temp_max_tenths)) begin
            tenths_r <= roi_csr_pkg::temp_max_tenths;
        end else begin
            tenths_r <= tenths_nxt[11:0];
        end
    end
endmodule : thermal_scale
`default_nettype wire

// file: roi_mode_csr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module roi_mode_csr_sva (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Quadlet access port
    input wire logic        acc_req,
    input wire logic        acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    input wire logic        acc_ack_r,
    input wire logic [31:0] acc_rdata_r,
    // Camera control
    input wire logic        scalable_format_on,
    input wire logic        capture_req,
    input wire logic        capture_start_r,
    input wire logic        capture_refused_r,
    input wire logic        settings_apply_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Access sequences
    // ----------------------------------------
    sequence s_rd(logic [31:0] a);
        acc_req && !acc_write && acc_addr == a;
    endsequence
    sequence s_apply;
        acc_req && acc_write && acc_addr == roi_csr_pkg::mode0_base + 32'h7c && acc_wdata[30];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ack;
        acc_req |=> acc_ack_r;
    endproperty
    property p_no_ack;
        !acc_req |=> !acc_ack_r;
    endproperty
    property p_ptr;
        s_rd(roi_csr_pkg::mode0_ptr_addr) |=> acc_rdata_r == 32'h003c2000;
    endproperty
    property p_apply;
        s_apply |=> settings_apply_r;
    endproperty
    property p_apply_src;
        settings_apply_r |-> $past(acc_req && acc_write);
    endproperty
    property p_thermal;
        s_rd(roi_csr_pkg::thermal_addr) |=> acc_rdata_r[31] && acc_rdata_r[25]
            && acc_rdata_r[29:26] == 4'h0 && acc_rdata_r[24:12] == 13'h0;
    endproperty
    property p_clamp;
        s_rd(roi_csr_pkg::thermal_addr) |=> $signed(acc_rdata_r[11:0]) >= -12'sd550
            && $signed(acc_rdata_r[11:0]) <= 12'sd1500;
    endproperty
    property p_granule;
        s_rd(roi_csr_pkg::mode0_base + 32'h40) |=> acc_rdata_r[31:16] == 16'h0004;
    endproperty
    property p_cap;
        capture_req |=> capture_start_r != capture_refused_r;
    endproperty
    property p_cap_idle;
        !capture_req |=> !capture_start_r && !capture_refused_r;
    endproperty
    property p_free;
        capture_req && !scalable_format_on |=> capture_start_r;
    endproperty
    a_ack:       assert property (p_ack) else $error("ack missing");
    a_no_ack:    assert property (p_no_ack) else $error("ack without request");
    a_ptr:       assert property (p_ptr) else $error("pointer wrong");
    a_apply:     assert property (p_apply) else $error("apply missing");
    a_apply_src: assert property (p_apply_src) else $error("apply without write");
    a_thermal:   assert property (p_thermal) else $error("thermal bits");
    a_clamp:     assert property (p_clamp) else $error("thermal range");
    a_granule:   assert property (p_granule) else $error("granule");
    a_cap:       assert property (p_cap) else $error("capture answer");
    a_cap_idle:  assert property (p_cap_idle) else $error("capture idle");
    a_free:      assert property (p_free) else $error("capture refused");
endmodule : roi_mode_csr_sva
bind roi_mode_csr roi_mode_csr_sva u_roi_mode_csr_sva (.clock(clock), .srst(srst),
    .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_ack_r(acc_ack_r), .acc_rdata_r(acc_rdata_r), .scalable_format_on(scalable_format_on),
    .capture_req(capture_req), .capture_start_r(capture_start_r),
    .capture_refused_r(capture_refused_r), .settings_apply_r(settings_apply_r));
`default_nettype wire

// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic        clock,
    // Quadlet access port
    output logic             acc_req,
    output logic             acc_write,
    output logic [31:0]      acc_addr,
    output logic [31:0]      acc_wdata,
    input  wire logic        acc_ack_r,
    input  wire logic [31:0] acc_rdata_r
);
    // Idle bus at time zero
    initial begin
        acc_req   = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 32'h0;
        acc_wdata = 32'h0;
    end
    // One quadlet; released lines show inverted values
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic hung);
        @(negedge clock);
        acc_req   = 1'b1;
        acc_write = wr;
        acc_addr  = a;
        acc_wdata = d;
        @(negedge clock);
        acc_req   = 1'b0;
        acc_write = ~wr;
        acc_addr  = ~a;
        acc_wdata = ~d;
        hung      = !(acc_ack_r === 1'b1);
        q         = acc_rdata_r;
    endtask : access
endmodule : host_model
`default_nettype wire

// file: roi_mode_csr_test.sv
`timescale 1ns/1ps
`default_nettype none
module roi_mode_csr_test;
    logic               clock, srst, initialize, scalable_format_on, active_mode, capture_req;
    logic               acc_req, acc_write, acc_ack_r, capture_start_r, capture_refused_r;
    logic               settings_apply_r;
    logic [31:0]        acc_addr, acc_wdata, acc_rdata_r, q, p;
    logic signed [11:0] sensor_quarter_deg;
    int                 num_errors = 0;
    int                 n_compared = 0;
    localparam logic [31:0] b0 = roi_csr_pkg::mode0_base;
    // Clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    roi_mode_csr u_roi_mode_csr (.clock(clock), .srst(srst), .acc_req(acc_req),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_ack_r(acc_ack_r), .acc_rdata_r(acc_rdata_r), .initialize(initialize),
        .scalable_format_on(scalable_format_on), .active_mode(active_mode),
        .capture_req(capture_req), .capture_start_r(capture_start_r),
        .capture_refused_r(capture_refused_r), .settings_apply_r(settings_apply_r),
        .sensor_quarter_deg(sensor_quarter_deg));
    host_model u_host_model (.clock(clock), .acc_req(acc_req), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack_r(acc_ack_r),
        .acc_rdata_r(acc_rdata_r));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        logic h;
        u_host_model.access(wr, a, d, q, h);
        if (h) begin
            num_errors++;
            wrap_up();
        end
    endtask : acc
    task automatic cap(input logic ok);
        @(negedge clock);
        capture_req = 1'b1;
        @(negedge clock);
        capture_req = 1'b0;
        check({capture_start_r, capture_refused_r}, ok ? 32'h2 : 32'h1);
    endtask : cap
    function automatic logic [11:0] tenths(input int qd);
        int v;
        v = (qd * 5) >>> 1;
        if (v < -550) v = -550;
        if (v > 1500) v = 1500;
        return v[11:0];
    endfunction : tenths
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ptr;
        acc(0, roi_csr_pkg::mode0_ptr_addr, 0);
        p = q;
        check(p, 32'h003c2000);
        acc(0, roi_csr_pkg::mode1_ptr_addr, 0);
        check(q, 32'h003c2400);
        acc(0, 32'hf0000000 + (q << 2), 0);
        check(q, {roi_csr_pkg::max_width, roi_csr_pkg::max_height});
        acc(0, 32'hf0000000 + (p << 2), 0);
        check(q, {roi_csr_pkg::max_width, roi_csr_pkg::max_height});
        $display("t_ptr done");
    endtask : t_ptr
    task automatic t_inq;
        acc(1, b0 + 32'h40, 32'h0);
        acc(0, b0 + 32'h40, 0);
        check(q, {roi_csr_pkg::packet_size_granule, roi_csr_pkg::packet_max_bytes});
        acc(1, b0 + 32'h24, 32'hffffffff);
        acc(0, b0 + 32'h24, 0);
        check(q, (32'h1 << (31 - (132 - 128))) | (32'h1 << (31 - (136 - 128))));
        acc(0, b0 + 32'h30, 0);
        check(q, 32'h0);
        $display("t_inq done");
    endtask : t_inq
    task automatic t_err;
        scalable_format_on = 1'b1;
        acc(1, b0 + 32'h0c, {16'h0, roi_csr_pkg::max_height});
        acc(0, b0 + 32'h7c, 0);
        check(q[23:22], 2'b10);
        cap(0);
        active_mode = 1'b1;
        cap(1);
        active_mode = 1'b0;
        scalable_format_on = 1'b0;
        cap(1);
        scalable_format_on = 1'b1;
        acc(1, b0 + 32'h0c, {roi_csr_pkg::max_width, roi_csr_pkg::max_height});
        acc(1, b0 + 32'h44, 32'h0);
        acc(0, b0 + 32'h7c, 0);
        check(q[23:22], 2'b01);
        cap(0);
        acc(1, b0 + 32'h44, {roi_csr_pkg::payload_default, 16'h0});
        acc(0, b0 + 32'h7c, 0);
        check(q[31:22], 10'h200);
        cap(1);
        acc(1, b0 + 32'h7c, 32'h40000000);
        check(settings_apply_r, 1);
        acc(0, b0 + 32'h7c, 0);
        check(q[30], 0);
        acc(0, b0 + 32'h34, 0);
        check(q, 32'h00300000);
        $display("t_err done");
    endtask : t_err
    task automatic t_init;
        acc(1, b0 + 32'h10, {roi_csr_pkg::packed_twelve_bit_mono_coding, 24'h0});
        acc(0, b0 + 32'h10, 0);
        check(q, 32'h84000000);
        @(negedge clock) initialize = 1'b1;
        @(negedge clock) initialize = 1'b0;
        acc(0, b0 + 32'h10, 0);
        check(q, {roi_csr_pkg::format_default, 24'h0});
        acc(1, b0 + 32'h10, {roi_csr_pkg::packed_twelve_bit_raw_coding, 24'h0});
        @(negedge clock) srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        acc(0, b0 + 32'h10, 0);
        check(q, {roi_csr_pkg::format_default, 24'h0});
        $display("t_init done");
    endtask : t_init
    task automatic t_temp;
        int tq[4] = '{100, -400, 1000, -1};
        foreach (tq[i]) begin
            sensor_quarter_deg = tq[i][11:0];
            repeat (3) @(negedge clock);
            acc(0, roi_csr_pkg::thermal_addr, 0);
            check(q[11:0], tenths(tq[i]));
        end
        acc(1, roi_csr_pkg::thermal_addr, 32'hffffffff);
        acc(0, roi_csr_pkg::thermal_addr, 0);
        check(q & 32'hfffff000, 32'hc2000000);
        acc(1, roi_csr_pkg::thermal_addr, 32'h0);
        acc(0, roi_csr_pkg::thermal_addr, 0);
        check(q, {20'h82000, tenths(-1)});
        $display("t_temp done");
    endtask : t_temp
    // Main sequence
    initial begin
        srst = 1'b1;
        initialize = 1'b0;
        scalable_format_on = 1'b0;
        active_mode = 1'b0;
        capture_req = 1'b0;
        sensor_quarter_deg = 12'sh0;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        t_ptr();
        t_inq();
        t_err();
        t_init();
        t_temp();
        wrap_up();
    end
endmodule : roi_mode_csr_test
`default_nettype wire
